// ==== bench/source_list_sequencer_test.sv ====
// Self-checking bench for the list sequencer over APB.
// Assumes the trigger partner model and the package's register map.
`default_nettype none
module source_list_sequencer_test;
  import list_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic trig_in_pin, output_on_pin, limit_exceeded_pin, fire;
  logic dio2_out, dio2_oe, running, er, wide_seen;
  src_cmd_type src_q;
  logic [15:0] src_volt_mv, src_ilim_ma;
  int miscompares, cmp_count, n, base, pulse_cnt;

  list_seq uut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in_pin(trig_in_pin), .output_on_pin(output_on_pin),
    .limit_exceeded_pin(limit_exceeded_pin), .dio2_out(dio2_out),
    .dio2_oe(dio2_oe), .src_q(src_q), .src_volt_mv(src_volt_mv),
    .src_ilim_ma(src_ilim_ma), .running(running));
  trig_partner pm (.core_clk(core_clk), .rst(rst), .fire(fire),
    .dio2_out(dio2_out), .dio2_oe(dio2_oe), .trig_in_pin(trig_in_pin),
    .pulse_cnt(pulse_cnt), .wide_seen(wide_seen));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task test_done();
    $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  // Setup, then access held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Ready, read data and error are taken at the same rising edge
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for the running flag to reach a level
  task wait_run(input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge core_clk);
      if (running === v) break;
    end
    chk("running", running, v);
  endtask : wait_run

  // Short timing: 1 us delay and 1 us per sample
  task cfg(input logic [31:0] c, l, d, k);
    apb(1'b1, OFF_CTRL, c);
    apb(1'b1, OFF_LIST, l);
    apb(1'b1, OFF_DWELL, d);
    apb(1'b1, OFF_DELAY, 32'h0000_0001);
    apb(1'b1, OFF_SPEED, 32'h0000_0001);
    apb(1'b1, OFF_COUNT, k);
  endtask : cfg

  task go();
    base = pulse_cnt;
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    wait_run(1'b1, 10);
  endtask : go

  task trig(input int s);
    if (s == 1) begin
      @(posedge core_clk);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
    end else begin
      apb(1'b1, OFF_CMD, (s == 2) ? 32'h0000_0004 : 32'h0000_0002);
    end
  endtask : trig

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    apb(1'b0, OFF_LIST, 32'h0);
    chk("list", rd, 32'h0001_0100);
    apb(1'b0, OFF_DWELL, 32'h0);
    chk("dwell", rd[15:0], RST_DWELL);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk("delay", rd[15:0], RST_DELAY);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", er, 1'b1);
    chk("oe", dio2_oe, 1'b1);
    apb(1'b1, OFF_LIST, 32'h0001_010C);
    apb(1'b0, OFF_LIST, 32'h0);
    chk("list num", rd[3:0], 4'h0);
  endtask : t_reset

  task t_step_imm();
    cfg(32'h0, 32'h0001_0301, 32'h0000_0004, 32'h0000_0009);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("samples", rd[15:0], 16'h0003);
    go();
    wait_run(1'b0, 2000);
    chk("pulses", pulse_cnt - base, 3);
    chk("zero end", src_q.zero_end, 1'b0);
    chk("list sel", src_q.list_num, 4'h1);
    chk("last point", src_q.point, 8'h02);
    chk("active", src_q.active, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0200);
  endtask : t_step_imm

  // Dwell of 1 ms would overrun the wait if it were not ignored
  task t_sweep_point();
    cfg(32'h0000_0007, 32'h0002_0202, 32'h0000_03E8, 32'h0000_0002);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("samples", rd[15:0], 16'h0002);
    go();
    wait_run(1'b0, 1500);
    chk("pulses", pulse_cnt - base, 2);
    chk("volt", src_volt_mv, ZERO_VOLT_MV);
    chk("ilim", src_ilim_ma, ZERO_ILIM_MA);
    chk("zero flag", src_q.zero_end, 1'b1);
  endtask : t_sweep_point

  task t_step_trig(input int s);
    cfg(s << 4, 32'h0001_0201, 32'h0000_0004, 32'h0000_0001);
    go();
    trig(s);
    for (int i = 0; i < 500 && pulse_cnt == base; i++) @(negedge core_clk);
    repeat (200) @(posedge core_clk);
    chk("held", pulse_cnt - base, 1);
    trig(s);
    wait_run(1'b0, 500);
    chk("pulses", pulse_cnt - base, 2);
  endtask : t_step_trig

  task t_abort(input int k);
    cfg((k == 2) ? 32'h0000_0100 : 32'h0, 32'h0001_0801, 32'h4, 32'h1);
    go();
    repeat (30) @(posedge core_clk);
    if (k == 0) output_on_pin <= 1'b0;
    if (k == 2) limit_exceeded_pin <= 1'b1;
    if (k == 1) apb(1'b1, OFF_CMD, 32'h0000_0008);
    wait_run(1'b0, 10);
    repeat (200) @(posedge core_clk);
    chk("no step", pulse_cnt - base, 0);
    output_on_pin <= 1'b1;
    limit_exceeded_pin <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask : t_abort

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    output_on_pin = 1'b1;
    limit_exceeded_pin = 1'b0;
    fire = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    chk("ilim rst", src_ilim_ma, 16'h0064);
    t_reset();
    t_step_imm();
    t_sweep_point();
    for (int s = 1; s < 4; s++) t_step_trig(s);
    for (int k = 0; k < 3; k++) t_abort(k);
    chk("pulse width", wide_seen, 1'b0);
    test_done();
  end
endmodule : source_list_sequencer_test
`default_nettype wire

// ==== bench/trig_partner.sv ====
// Far side model: external trigger source and a listener on DIO line 2.
// Assumes the bench asks for a trigger by raising fire for one cycle.
`default_nettype none
module trig_partner (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic dio2_out,
  input wire logic dio2_oe,
  output var logic trig_in_pin,
  output var int pulse_cnt,
  output var logic wide_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  int hold_cnt;
  logic dio2_last;

  // ----------------------------------------------------------------
  // Trigger source
  // ----------------------------------------------------------------
  // Held several cycles so the design's synchroniser cannot miss it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt <= 0;
    end else if (fire) begin
      hold_cnt <= 6;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end

  // Line rests low outside a trigger request
  always_ff @(posedge core_clk) begin
    trig_in_pin <= (hold_cnt != 0);
  end

  // ----------------------------------------------------------------
  // Listener
  // ----------------------------------------------------------------
  // Only a driven line counts; a pulse of two cycles is flagged
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulse_cnt <= 0;
      wide_seen <= 1'b0;
      dio2_last <= 1'b0;
    end else begin
      dio2_last <= dio2_out && dio2_oe;
      if (dio2_out && dio2_oe && !dio2_last) begin
        pulse_cnt <= pulse_cnt + 1;
      end
      if (dio2_out && dio2_last) begin
        wide_seen <= 1'b1;
      end
    end
  end
endmodule : trig_partner
`default_nettype wire

// ==== core/list_seq.sv ====
// Source list sequencer: steps a source through a stored list with a
// source-delay-measure cycle per step, driving measure complete on DIO 2.
// Assumes APB from the same core_clk; trigger and output-enable pins are
// asynchronous and are synchronised here.
//
// Our own choices: the APB slave port and the placing of the registers.
`default_nettype none
module list_seq
  import list_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_in_pin,
  input wire logic output_on_pin,
  input wire logic limit_exceeded_pin,
  output logic dio2_out,
  output logic dio2_oe,
  output src_cmd_type src_q,
  output logic [15:0] src_volt_mv,
  output logic [15:0] src_ilim_ma,
  output logic running
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] list_q;
  logic [15:0] dwell_q, delay_q, speed_q, samples_q;
  seq_state_type state_q;
  logic [15:0] tick_cnt_q;
  logic [15:0] unit_cnt_q;
  logic [15:0] smp_cnt_q;
  logic [7:0] point_q;
  logic [15:0] cycle_q;
  logic [4:0] pre_q;
  logic tick;
  logic enable_cmd, manual_cmd, bus_cmd, abort_cmd;
  logic [2:0] trig_sync_q, out_sync_q, lim_sync_q;
  logic ext_edge, out_off, lim_hit;
  logic trig_ok, stop, last_point, last_cycle;
  logic [15:0] window;
  logic [15:0] win_samples;
  logic hold_point, zero_end, sweep;
  arm_src_type arm_src;
  logic [3:0] list_num;
  logic [7:0] n_points;
  logic [15:0] n_cycles;

  assign hold_point = ctrl_q[CTRL_HOLD_POINT];
  assign zero_end = ctrl_q[CTRL_ZERO_END];
  assign sweep = ctrl_q[CTRL_SWEEP];
  assign arm_src = arm_src_type'(ctrl_q[CTRL_ARM_LSB +: 2]);
  assign list_num = list_q[LIST_NUM_LSB +: 4];
  assign n_points = list_q[LIST_PTS_LSB +: 8];
  assign n_cycles = list_q[LIST_CYC_LSB +: 16];

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped offsets
  // ----------------------------------------------------------------
  logic apb_wr, apb_rd, mapped;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_STATUS);

  // Configuration writes; an out-of-range list number falls back to demo
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= 32'h0000_0000;
      list_q <= {RST_CYCLES, RST_POINTS, 4'h0, LIST_DEMO};
      dwell_q <= RST_DWELL;
      delay_q <= RST_DELAY;
      speed_q <= RST_SPEED;
      samples_q <= RST_SAMPLES;
    end else if (apb_wr && state_q == ST_IDLE) begin
      unique case (paddr)
        OFF_CTRL: ctrl_q <= pwdata & 32'h0000_0137;
        OFF_LIST: begin
          list_q <= pwdata & 32'hFFFF_FF0F;
          if (pwdata[3:0] > LIST_MAX) begin
            list_q[3:0] <= LIST_DEMO;
          end
        end
        OFF_DWELL: dwell_q <= pwdata[15:0];
        OFF_DELAY: delay_q <= pwdata[15:0];
        OFF_SPEED: speed_q <= pwdata[15:0];
        OFF_COUNT: samples_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Command strobes act only on the completing access cycle
  assign enable_cmd = apb_wr && paddr == OFF_CMD && pwdata[CMD_ENABLE];
  assign manual_cmd = apb_wr && paddr == OFF_CMD && pwdata[CMD_MANUAL];
  assign bus_cmd = apb_wr && paddr == OFF_CMD && pwdata[CMD_BUS];
  assign abort_cmd = apb_wr && paddr == OFF_CMD && pwdata[CMD_ABORT];

  // Read data is captured in setup so it is stable in the access phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (apb_rd) begin
        unique case (paddr)
          OFF_CTRL: prdata <= ctrl_q;
          OFF_LIST: prdata <= list_q;
          OFF_DWELL: prdata <= {16'h0000, dwell_q};
          OFF_DELAY: prdata <= {16'h0000, delay_q};
          OFF_SPEED: prdata <= {16'h0000, speed_q};
          OFF_COUNT: prdata <= {16'h0000, win_samples};
          OFF_STATUS: prdata <= {cycle_q, point_q, 5'h00, state_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers; only the second and third stages are read
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_sync_q <= 3'h0;
      // Output-on pin idles high, so reset to on to avoid a false off
      out_sync_q <= 3'h7;
      lim_sync_q <= 3'h0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trig_in_pin};
      out_sync_q <= {out_sync_q[1:0], output_on_pin};
      lim_sync_q <= {lim_sync_q[1:0], limit_exceeded_pin};
    end
  end
  assign ext_edge = trig_sync_q[1] & ~trig_sync_q[2];
  assign out_off = ~out_sync_q[1];
  assign lim_hit = lim_sync_q[1] & ctrl_q[CTRL_LIMIT_ABORT];

  // Stop sources: output off, limit, bus abort command
  assign stop = (state_q != ST_IDLE) &
                (out_off | lim_hit | abort_cmd);

  // Trigger in from the selected source, only honoured when waiting
  always_comb begin
    unique case (arm_src)
      ARM_IMMEDIATE: trig_ok = 1'b1;
      ARM_EXTERNAL: trig_ok = ext_edge;
      ARM_BUS: trig_ok = bus_cmd;
      ARM_MANUAL: trig_ok = manual_cmd;
    endcase
  end

  // ----------------------------------------------------------------
  // Window arithmetic
  // ----------------------------------------------------------------
  // Time hold samples the dwell less delay; guard small dwell values
  always_comb begin
    if (hold_point) begin
      window = 16'(samples_q * speed_q);
      win_samples = samples_q;
    end else begin
      window = (dwell_q > delay_q) ? 16'(dwell_q - delay_q) : 16'h0001;
      win_samples = (speed_q == 16'h0000) ? 16'h0001 :
                    16'(window / speed_q);
    end
  end

  // Microsecond tick divider from the core clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pre_q <= 5'h00;
    end else if (pre_q == 5'(TICK_CYC - 1)) begin
      pre_q <= 5'h00;
    end else begin
      pre_q <= pre_q + 5'h01;
    end
  end
  assign tick = (pre_q == 5'(TICK_CYC - 1));

  assign last_point = (point_q + 8'h01 >= n_points);
  assign last_cycle = (cycle_q + 16'h0001 >= n_cycles);

  // ----------------------------------------------------------------
  // Sequencer: delay, measure, dwell, done, wait for trigger
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      tick_cnt_q <= 16'h0000;
      smp_cnt_q <= 16'h0000;
      unit_cnt_q <= 16'h0000;
      point_q <= 8'h00;
      cycle_q <= 16'h0000;
    end else if (stop) begin
      state_q <= ST_IDLE;
      tick_cnt_q <= 16'h0000;
      smp_cnt_q <= 16'h0000;
      unit_cnt_q <= 16'h0000;
    end else begin
      if (tick) begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
      unique case (state_q)
        ST_IDLE: begin
          // Enable or a manual trigger restarts from the first point
          if ((enable_cmd | manual_cmd) && !out_off) begin
            state_q <= ST_DELAY;
            point_q <= 8'h00;
            cycle_q <= 16'h0000;
            tick_cnt_q <= 16'h0000;
          end
        end
        ST_DELAY: begin
          if (tick && tick_cnt_q + 16'h0001 >= delay_q) begin
            // Tick count runs on so dwell is timed from the step start
            state_q <= ST_MEASURE;
            unit_cnt_q <= 16'h0000;
            smp_cnt_q <= 16'h0000;
          end
        end
        ST_MEASURE: begin
          // One sample per speed period; window ends after win_samples
          if (tick && unit_cnt_q + 16'h0001 >= speed_q) begin
            unit_cnt_q <= 16'h0000;
            smp_cnt_q <= smp_cnt_q + 16'h0001;
            if (smp_cnt_q + 16'h0001 >= win_samples) begin
              state_q <= hold_point ? ST_DONE : ST_DWELL;
            end
          end else if (tick) begin
            unit_cnt_q <= unit_cnt_q + 16'h0001;
          end
        end
        ST_DWELL: begin
          if (tick_cnt_q >= dwell_q) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          tick_cnt_q <= 16'h0000;
          if (last_point && last_cycle) begin
            state_q <= ST_IDLE;
          end else begin
            point_q <= last_point ? 8'h00 : point_q + 8'h01;
            cycle_q <= last_point ? cycle_q + 16'h0001 : cycle_q;
            // Sweep and immediate arming run on; other step arming waits for a fresh trigger
            state_q <= (sweep || arm_src == ARM_IMMEDIATE) ?
                       ST_DELAY : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (trig_ok) begin
            state_q <= ST_DELAY;
            tick_cnt_q <= 16'h0000;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // triggers outside ST_WAIT and ST_IDLE are simply not looked at

  // ----------------------------------------------------------------
  // Measure complete pulse on DIO line 2
  // ----------------------------------------------------------------
  // Step mode pulses each step, sweep only at the end of each cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dio2_out <= 1'b0;
      dio2_oe <= 1'b0;
    end else begin
      dio2_oe <= 1'b1;
      dio2_out <= !stop && state_q == ST_DONE &&
                  (!sweep || last_point);
    end
  end

  // ----------------------------------------------------------------
  // Source setpoint
  // ----------------------------------------------------------------
  // Zero end overrides levels only after a natural completion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_q <= '0;
      src_volt_mv <= ZERO_VOLT_MV;
      src_ilim_ma <= ZERO_ILIM_MA;
      running <= 1'b0;
    end else begin
      running <= !stop && state_q != ST_IDLE;
      src_q.list_num <= list_num;
      src_q.point <= point_q;
      src_q.active <= !stop && state_q != ST_IDLE;
      if (!stop && state_q == ST_DONE && last_point && last_cycle) begin
        src_q.zero_end <= zero_end;
        if (zero_end) begin
          src_volt_mv <= ZERO_VOLT_MV;
          src_ilim_ma <= ZERO_ILIM_MA;
        end
      end else if (state_q == ST_DELAY) begin
        src_q.zero_end <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_done_step;
    state_q == ST_DONE && !stop && !sweep;
  endsequence

  a_mc_single_pulse: assert property (@(posedge core_clk) disable iff (rst)
    dio2_out |=> !dio2_out)
    else $error("measure complete longer than one cycle");

  a_step_mc_each: assert property (@(posedge core_clk) disable iff (rst)
    s_done_step |=> dio2_out)
    else $error("step mode missed measure complete");

  a_sweep_mc_cycle: assert property (@(posedge core_clk) disable iff (rst)
    sweep && state_q == ST_DONE && !last_point |=> !dio2_out)
    else $error("sweep pulsed mid cycle");

  a_stop_to_idle: assert property (@(posedge core_clk) disable iff (rst)
    stop |=> state_q == ST_IDLE)
    else $error("list not aborted");

  a_limit_abort: assert property (@(posedge core_clk) disable iff (rst)
    lim_hit && state_q != ST_IDLE |=> state_q == ST_IDLE)
    else $error("limit did not stop list");

  a_stop_no_mc: assert property (@(posedge core_clk) disable iff (rst)
    stop |=> !dio2_out ##1 !running)
    else $error("activity after stop");

  a_wait_holds: assert property (@(posedge core_clk) disable iff (rst)
    state_q == ST_WAIT && !trig_ok && !stop |=> state_q == ST_WAIT)
    else $error("advanced without trigger");

  a_imm_no_wait: assert property (@(posedge core_clk) disable iff (rst)
    (s_done_step and
     (arm_src == ARM_IMMEDIATE && !(last_point && last_cycle)))
    |=> state_q == ST_DELAY)
    else $error("immediate step did not continue");

  a_point_skip_dwell: assert property (@(posedge core_clk) disable iff (rst)
    hold_point |-> state_q != ST_DWELL)
    else $error("dwell used in point hold");

  a_zero_end: assert property (@(posedge core_clk) disable iff (rst)
    state_q == ST_DONE && !stop && last_point && last_cycle && zero_end
    |=> src_volt_mv == ZERO_VOLT_MV && src_ilim_ma == ZERO_ILIM_MA)
    else $error("zero end levels wrong");

  a_dio2_driven: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> dio2_oe)
    else $error("line 2 not driven");

endmodule : list_seq
`default_nettype wire

// ==== pkg/list_seq_pkg.sv ====
// Package for the source list sequencer: register map, field layout,
// reset values, timing constants and shared types.
// Assumes a 20 MHz core clock and a 32-bit APB register bus.
`default_nettype none
package list_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  // Base tick of dwell, delay and sample time counts
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LIST = 8'h04;
  localparam logic [7:0] OFF_DWELL = 8'h08;
  localparam logic [7:0] OFF_DELAY = 8'h0C;
  localparam logic [7:0] OFF_SPEED = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // CTRL fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_HOLD_POINT = 0;
  localparam int unsigned CTRL_ZERO_END = 1;
  localparam int unsigned CTRL_SWEEP = 2;
  localparam int unsigned CTRL_ARM_LSB = 4;
  localparam int unsigned CTRL_LIMIT_ABORT = 8;

  // LIST fields: number in [3:0], points in [15:8], cycles in [31:16]
  localparam int unsigned LIST_NUM_LSB = 0;
  localparam int unsigned LIST_PTS_LSB = 8;
  localparam int unsigned LIST_CYC_LSB = 16;

  // CMD bits (write one to act)
  localparam int unsigned CMD_ENABLE = 0;
  localparam int unsigned CMD_MANUAL = 1;
  localparam int unsigned CMD_BUS = 2;
  localparam int unsigned CMD_ABORT = 3;

  // ----------------------------------------------------------------
  // Reset values and the highest list number
  // ----------------------------------------------------------------
  localparam logic [3:0] LIST_DEMO = 4'h0;
  localparam logic [3:0] LIST_MAX = 4'h9;
  localparam logic [7:0] RST_POINTS = 8'h01;
  localparam logic [15:0] RST_CYCLES = 16'h0001;
  localparam logic [15:0] RST_DWELL = 16'h0064;
  localparam logic [15:0] RST_DELAY = 16'h000A;
  localparam logic [15:0] RST_SPEED = 16'h000A;
  localparam logic [15:0] RST_SAMPLES = 16'h0001;

  // Zero end levels: 0 V, 100 mA limit (mV and mA units)
  localparam logic [15:0] ZERO_VOLT_MV = 16'h0000;
  localparam logic [15:0] ZERO_ILIM_MA = 16'h0064;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ARM_IMMEDIATE = 2'b00,
    ARM_EXTERNAL = 2'b01,
    ARM_BUS = 2'b10,
    ARM_MANUAL = 2'b11
  } arm_src_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_MEASURE = 3'b010,
    ST_DWELL = 3'b011,
    ST_DONE = 3'b100,
    ST_WAIT = 3'b101
  } seq_state_type;

  // Source setpoint presented to the output stage
  typedef struct packed {
    logic active;
    logic zero_end;
    logic [3:0] list_num;
    logic [7:0] point;
  } src_cmd_type;

endpackage : list_seq_pkg
`default_nettype wire
